// >>> design/tcesr_pkg.sv
// Shared constants, encodings and carrier types of the Type-C event and status register bank
package tcesr_pkg;

   // Register offsets on the serial bus
   localparam logic [7:0] REG_DEVICE_ID   = 8'h01;
   localparam logic [7:0] REG_CONTROL     = 8'h02;
   localparam logic [7:0] REG_EVENT_FLAGS = 8'h03;
   localparam logic [7:0] REG_CONN_STATUS = 8'h04;

   // Values after reset
   localparam logic [7:0] CONTROL_RST     = 8'h00;
   localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
   localparam logic [7:0] POINTER_RST     = 8'h00;
   localparam logic [7:0] SHIFT_RST       = 8'h00;
   localparam logic [3:0] BIT_COUNT_RST   = 4'h0;

   // Event flag bit positions
   localparam int EVT_RECOVERY   = 7;
   localparam int EVT_OCP        = 6;
   localparam int EVT_OVP        = 5;
   localparam int EVT_RESERVED   = 4;
   localparam int EVT_OTP        = 3;
   localparam int EVT_FAULT_LIVE = 2;
   localparam int EVT_DETACH     = 1;
   localparam int EVT_ATTACH     = 0;

   // Bits that latch and clear on read (7,6,5,3,1,0)
   localparam logic [7:0] EVT_LATCH_MASK = 8'heb;

   // Control register field
   localparam int CTRL_INT_MASK = 0;

   // Edge detector lane positions
   localparam int EDGE_OCP    = 0;
   localparam int EDGE_OVP    = 1;
   localparam int EDGE_OTP    = 2;
   localparam int EDGE_FAULT  = 3;
   localparam int EDGE_ATTACH = 4;
   localparam int EDGE_WIDTH  = 5;

   // Serial bus byte length
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Attached partner encodings
   localparam logic [2:0] PARTNER_STANDBY = 3'h0;
   localparam logic [2:0] PARTNER_DEVICE  = 3'h1;
   localparam logic [2:0] PARTNER_HOST    = 3'h2;
   localparam logic [2:0] PARTNER_AUDIO   = 3'h3;
   localparam logic [2:0] PARTNER_DEBUG   = 3'h4;

   // Detected charging current encodings
   localparam logic [1:0] CHARGE_STANDBY = 2'h0;
   localparam logic [1:0] CHARGE_DEFAULT = 2'h1;
   localparam logic [1:0] CHARGE_MEDIUM  = 2'h2;
   localparam logic [1:0] CHARGE_HIGH    = 2'h3;

   // Plug polarity encodings
   localparam logic [1:0] POLARITY_STANDBY = 2'h0;
   localparam logic [1:0] POLARITY_CC1     = 2'h1;
   localparam logic [1:0] POLARITY_CC2     = 2'h2;
   localparam logic [1:0] POLARITY_UNKNOWN = 2'h3;

   // Live connection status, laid out as the status register
   typedef struct packed {
      logic       vbus_detected;
      logic [1:0] charge_current;
      logic [2:0] partner;
      logic [1:0] polarity;
   } tcesr_status_t;

   // Live VCONN fault conditions
   typedef struct packed {
      logic overtemperature;
      logic overvoltage_protection;
      logic overcurrent_protection;
   } tcesr_fault_t;

   // Serial bus line sample
   typedef struct packed {
      logic scl;
      logic sda;
   } tcesr_line_t;

   // Serial slave states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WRITE,
      ST_WRITE_ACK,
      ST_READ,
      ST_READ_ACK
   } tcesr_state_t;

endpackage : tcesr_pkg

// >>> design/tcesr_edge_detect.sv
// Per-lane rise and fall detector for level inputs
`timescale 1ns/1ps
`default_nettype none

module tcesr_edge_detect
   import tcesr_pkg::*;
#(
   parameter int WIDTH = EDGE_WIDTH
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_b,
   // Levels in
   input  wire logic [WIDTH-1:0] i_level,
   // One-cycle pulses out
   output var  logic [WIDTH-1:0] o_rise,
   output var  logic [WIDTH-1:0] o_fall
);

   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_prev;

   // Previous level of every lane
   always_comb begin
      next_prev = i_level;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev <= '0;
      end else begin
         prev <= next_prev;
      end
   end

   // Zero after reset, so a level already high at release reports a rise
   for (genvar g = 0; g < WIDTH; g++) begin : g_lane
      assign o_rise[g] = i_level[g] & ~prev[g];
      assign o_fall[g] = ~i_level[g] & prev[g];
   end

endmodule : tcesr_edge_detect

`default_nettype wire

// >>> design/tcesr_i2c_cond.sv
// Serial bus line condition detector: start, stop and clock edges
`timescale 1ns/1ps
`default_nettype none

module tcesr_i2c_cond
   import tcesr_pkg::*;
(
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   // Bus lines, already synchronous
   input  wire logic i_scl,
   input  wire logic i_sda,
   // One-cycle conditions
   output var  logic o_start,
   output var  logic o_stop,
   output var  logic o_scl_rise,
   output var  logic o_scl_fall
);

   tcesr_line_t st;
   tcesr_line_t next_st;

   // Idle bus reads high on both lines
   always_comb begin
      next_st.scl = i_scl;
      next_st.sda = i_sda;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   // Data moving while clock stays high marks start or stop
   assign o_start    = st.scl & i_scl & st.sda & ~i_sda;
   assign o_stop     = st.scl & i_scl & ~st.sda & i_sda;
   assign o_scl_rise = ~st.scl & i_scl;
   assign o_scl_fall = st.scl & ~i_scl;

endmodule : tcesr_i2c_cond

`default_nettype wire

// >>> design/tcesr_top.sv
// Type-C event and status register bank with serial slave and open-drain interrupt pin
`timescale 1ns/1ps
`default_nettype none

module tcesr_top
   import tcesr_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h1d,  // Strap-selected address, plain default
   parameter logic [7:0] DEVICE_ID  = 8'h00   // Arbitrary neutral identification value
) (
   // Clock and reset
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst_b,
   // Serial bus, open drain
   input  wire logic          i_scl,
   input  wire logic          i_sda,
   output var  logic          o_sda,
   output var  logic          o_sda_oe_b,
   // Interrupt request, open drain
   output var  logic          o_interrupt_request_pin,
   output var  logic          o_interrupt_request_pin_oe_b,
   // Live conditions from the port logic
   input  wire tcesr_fault_t  i_fault,
   input  wire tcesr_status_t i_status
);

   // Whole module state
   typedef struct packed {
      tcesr_state_t fsm;
      logic [3:0]   bit_cnt;
      logic [7:0]   shreg;
      logic         rw;
      logic         first_write;
      logic         master_nack;
      logic [7:0]   ptr;
      logic [7:0]   ctrl;
      logic [7:0]   flags;
      logic         sda_out;
      logic         sda_oe_b;
      logic         irq_out;
      logic         irq_oe_b;
   } tcesr_top_state_t;

   tcesr_top_state_t       st;
   tcesr_top_state_t       next_st;

   logic                   cond_start;
   logic                   cond_stop;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   fault_any;
   logic                   attached;
   logic [EDGE_WIDTH-1:0]  edge_level;
   logic [EDGE_WIDTH-1:0]  edge_rise;
   logic [EDGE_WIDTH-1:0]  edge_fall;
   logic [7:0]             flags_view;
   logic [7:0]             read_byte;
   logic [7:0]             evt_set;
   logic                   rd_clear;
   logic                   irq_want;

   // Bus line conditions
   tcesr_i2c_cond u_cond (
      .i_sys_clk  (i_sys_clk),
      .i_rst_b    (i_rst_b),
      .i_scl      (i_scl),
      .i_sda      (i_sda),
      .o_start    (cond_start),
      .o_stop     (cond_stop),
      .o_scl_rise (scl_rise),
      .o_scl_fall (scl_fall)
   );

   // Fault and attach levels watched for edges
   // Attached means any partner code but standby
   assign fault_any = i_fault.overcurrent_protection | i_fault.overvoltage_protection | i_fault.overtemperature;
   assign attached  = (i_status.partner != PARTNER_STANDBY);

   // Lanes in the order the package numbers them
   always_comb begin
      edge_level              = '0;
      edge_level[EDGE_OCP]    = i_fault.overcurrent_protection;
      edge_level[EDGE_OVP]    = i_fault.overvoltage_protection;
      edge_level[EDGE_OTP]    = i_fault.overtemperature;
      edge_level[EDGE_FAULT]  = fault_any;
      edge_level[EDGE_ATTACH] = attached;
   end

   // Zero reset on purpose: a condition present at release becomes an event
   tcesr_edge_detect #(
      .WIDTH (EDGE_WIDTH)
   ) u_edge (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_level   (edge_level),
      .o_rise    (edge_rise),
      .o_fall    (edge_fall)
   );

   // Event pulses mapped onto flag positions
   always_comb begin
      evt_set                 = 8'h00;
      evt_set[EVT_RECOVERY]   = edge_fall[EDGE_FAULT];
      evt_set[EVT_OCP]        = edge_rise[EDGE_OCP];
      evt_set[EVT_OVP]        = edge_rise[EDGE_OVP];
      evt_set[EVT_OTP]        = edge_rise[EDGE_OTP];
      evt_set[EVT_DETACH]     = edge_fall[EDGE_ATTACH];
      evt_set[EVT_ATTACH]     = edge_rise[EDGE_ATTACH];
   end

   // Flag register as software sees it
   always_comb begin
      flags_view                 = st.flags & EVT_LATCH_MASK;
      flags_view[EVT_RESERVED]   = 1'b0;
      flags_view[EVT_FAULT_LIVE] = fault_any;
   end

   // Read data for the byte at the current pointer
   always_comb begin
      case (st.ptr)
         REG_DEVICE_ID: begin
            read_byte = DEVICE_ID;
         end
         REG_CONTROL: begin
            read_byte = st.ctrl;
         end
         REG_EVENT_FLAGS: begin
            read_byte = flags_view;
         end
         REG_CONN_STATUS: begin
            read_byte = i_status;
         end
         default: begin
            // Unmapped offsets read as zero
            read_byte = 8'h00;
         end
      endcase
   end

   // Next state: serial slave, register writes, flags and pin drive
   always_comb begin
      next_st  = st;
      rd_clear = 1'b0;
      irq_want = 1'b0;

      // Open-drain lines only ever drive zero
      next_st.sda_out = 1'b0;
      next_st.irq_out = 1'b0;

      if (cond_stop) begin
         next_st.fsm      = ST_IDLE;
         next_st.bit_cnt  = BIT_COUNT_RST;
         next_st.sda_oe_b = 1'b1;
      end else if (cond_start) begin
         // Repeated start lands here too, keeping the pointer
         next_st.fsm      = ST_ADDR;
         next_st.bit_cnt  = BIT_COUNT_RST;
         next_st.sda_oe_b = 1'b1;
      end else begin
         case (st.fsm)
            ST_IDLE: begin
               // Deaf to line traffic until the next start
               next_st.sda_oe_b = 1'b1;
            end

            ST_ADDR: begin
               // Shift on each rise, decide on the fall after bit eight
               if (scl_rise && st.bit_cnt != BITS_PER_BYTE) begin
                  next_st.shreg   = {st.shreg[6:0], i_sda};
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end else if (scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
                  next_st.bit_cnt = BIT_COUNT_RST;
                  if (st.shreg[7:1] == SLAVE_ADDR) begin
                     next_st.rw          = st.shreg[0];
                     next_st.first_write = 1'b1;
                     next_st.sda_oe_b    = 1'b0;
                     next_st.fsm         = ST_ADDR_ACK;
                  end else begin
                     // Not our address: sit out until the next start
                     next_st.fsm = ST_IDLE;
                  end
               end
            end

            ST_ADDR_ACK: begin
               // Acknowledge stands through the whole ninth clock
               if (scl_fall) begin
                  next_st.bit_cnt = BIT_COUNT_RST;
                  if (st.rw) begin
                     // Clear on load, so a stop mid-byte still counts as read
                     next_st.shreg    = read_byte;
                     next_st.sda_oe_b = read_byte[7];
                     next_st.ptr      = st.ptr + 8'h01;
                     rd_clear         = (st.ptr == REG_EVENT_FLAGS);
                     next_st.fsm      = ST_READ;
                  end else begin
                     next_st.sda_oe_b = 1'b1;
                     next_st.fsm      = ST_WRITE;
                  end
               end
            end

            ST_WRITE: begin
               if (scl_rise && st.bit_cnt != BITS_PER_BYTE) begin
                  next_st.shreg   = {st.shreg[6:0], i_sda};
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end else if (scl_fall && st.bit_cnt == BITS_PER_BYTE) begin
                  next_st.bit_cnt  = BIT_COUNT_RST;
                  next_st.sda_oe_b = 1'b0;
                  next_st.fsm      = ST_WRITE_ACK;
                  if (st.first_write) begin
                     // First byte after the address selects the register
                     next_st.ptr         = st.shreg;
                     next_st.first_write = 1'b0;
                  end else begin
                     // Only control is writable; others accept and drop the byte
                     if (st.ptr == REG_CONTROL) begin
                        next_st.ctrl = st.shreg;
                     end
                     next_st.ptr = st.ptr + 8'h01;
                  end
               end
            end

            ST_WRITE_ACK: begin
               // Let go after the ninth clock so the master drives again
               if (scl_fall) begin
                  next_st.sda_oe_b = 1'b1;
                  next_st.bit_cnt  = BIT_COUNT_RST;
                  next_st.fsm      = ST_WRITE;
               end
            end

            ST_READ: begin
               // Count on the rise, move data only while the clock is low
               if (scl_rise) begin
                  next_st.bit_cnt = st.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (st.bit_cnt == BITS_PER_BYTE) begin
                     // Release for the master's acknowledge
                     next_st.sda_oe_b = 1'b1;
                     next_st.bit_cnt  = BIT_COUNT_RST;
                     next_st.fsm      = ST_READ_ACK;
                  end else begin
                     next_st.shreg    = {st.shreg[6:0], 1'b0};
                     next_st.sda_oe_b = st.shreg[6];
                  end
               end
            end

            ST_READ_ACK: begin
               // Master acknowledge sampled while the clock is high
               if (scl_rise) begin
                  next_st.master_nack = i_sda;
               end else if (scl_fall) begin
                  next_st.bit_cnt = BIT_COUNT_RST;
                  if (!st.master_nack) begin
                     // Master wants more: next byte, pointer moves on
                     next_st.shreg    = read_byte;
                     next_st.sda_oe_b = read_byte[7];
                     next_st.ptr      = st.ptr + 8'h01;
                     rd_clear         = (st.ptr == REG_EVENT_FLAGS);
                     next_st.fsm      = ST_READ;
                  end else begin
                     next_st.sda_oe_b = 1'b1;
                     next_st.fsm      = ST_IDLE;
                  end
               end
            end

            default: begin
               // Stray state codes recover to idle, line released
               next_st.sda_oe_b = 1'b1;
               next_st.fsm      = ST_IDLE;
            end
         endcase
      end

      // Set beats clear, so an event during the read is kept for the next one
      next_st.flags = (((rd_clear ? 8'h00 : st.flags) | evt_set) & EVT_LATCH_MASK);

      // Live fault bit is outside the latch mask and never requests
      irq_want = |(next_st.flags & EVT_LATCH_MASK);

      // Mask bit gates the pin, latched flags stay visible to reads
      if (next_st.ctrl[CTRL_INT_MASK]) begin
         next_st.irq_oe_b = 1'b1;
      end else begin
         next_st.irq_oe_b = ~irq_want;
      end
   end

   // State register
   // Pins come up released and unmasked, ready for the first event
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st.fsm         <= ST_IDLE;
         st.bit_cnt     <= BIT_COUNT_RST;
         st.shreg       <= SHIFT_RST;
         st.rw          <= 1'b0;
         st.first_write <= 1'b0;
         st.master_nack <= 1'b1;
         st.ptr         <= POINTER_RST;
         st.ctrl        <= CONTROL_RST;
         st.flags       <= EVENT_FLAGS_RST;
         st.sda_out     <= 1'b0;
         st.sda_oe_b    <= 1'b1;
         st.irq_out     <= 1'b0;
         st.irq_oe_b    <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Pins straight from flops
   // Drive levels are constant zero; only the enables move
   assign o_sda                        = st.sda_out;
   assign o_sda_oe_b                   = st.sda_oe_b;
   assign o_interrupt_request_pin      = st.irq_out;
   assign o_interrupt_request_pin_oe_b = st.irq_oe_b;

endmodule : tcesr_top

`default_nettype wire

// >>> tb/tcesr_top_props.sv
// Port-level assertions for the Type-C event and status register bank
`timescale 1ns/1ps
`default_nettype none

module tcesr_top_props
   import tcesr_pkg::*;
(
   // Clock and reset
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst_b,
   // Serial bus
   input  wire logic          i_scl,
   input  wire logic          i_sda,
   input  wire logic          o_sda,
   input  wire logic          o_sda_oe_b,
   // Interrupt pin
   input  wire logic          o_interrupt_request_pin,
   input  wire logic          o_interrupt_request_pin_oe_b,
   // Live conditions
   input  wire tcesr_fault_t  i_fault,
   input  wire tcesr_status_t i_status
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);

   // Open-drain pins may only ever pull low
   a_irq_drive_zero: assert property (o_interrupt_request_pin == 1'b0)
      else $error("interrupt pin drives a high level");
   a_sda_drive_zero: assert property (o_sda == 1'b0)
      else $error("data line drives a high level");

   // Pin pulls only for an input event, a control write or the first cycle out of reset
   a_irq_fall_cause: assert property ($fell(o_interrupt_request_pin_oe_b) |->
      !$past(i_rst_b, 2) || ($past(i_fault, 1) != $past(i_fault, 2))
      || ($past(i_status.partner == 3'h0, 1) != $past(i_status.partner == 3'h0, 2))
      || ($past(i_scl, 2) && !$past(i_scl, 1)))
      else $error("interrupt pin pulled with no event");

   // Release comes only from a register access, landing one cycle after SCL falls
   a_irq_release_cause: assert property ($rose(o_interrupt_request_pin_oe_b) |->
      $past(i_scl, 2) && !$past(i_scl, 1))
      else $error("interrupt pin released outside a register access");

   // Slave data moves after SCL falls, or on a stop
   a_sda_edge_cause: assert property ($changed(o_sda_oe_b) |->
      ($past(i_scl, 2) && !$past(i_scl, 1)) || ($past(i_scl, 1) && $past(i_sda, 1) && !$past(i_sda, 2)))
      else $error("data line changed outside the low clock phase");
   a_ack_stands: assert property ($fell(o_sda_oe_b) |-> !o_sda_oe_b [*3])
      else $error("driven data bit too short");
   a_stop_releases: assert property (i_scl && $past(i_scl) && i_sda && !$past(i_sda) |-> ##[1:2] o_sda_oe_b)
      else $error("data line held after stop");
   a_reset_released: assert property ($rose(i_rst_b) |-> o_sda_oe_b && o_interrupt_request_pin_oe_b)
      else $error("pins not released out of reset");
endmodule : tcesr_top_props

bind tcesr_top tcesr_top_props tcesr_top_props_i (
   .i_sys_clk(i_sys_clk),
   .i_rst_b(i_rst_b),
   .i_scl(i_scl),
   .i_sda(i_sda),
   .o_sda(o_sda),
   .o_sda_oe_b(o_sda_oe_b),
   .o_interrupt_request_pin(o_interrupt_request_pin),
   .o_interrupt_request_pin_oe_b(o_interrupt_request_pin_oe_b),
   .i_fault(i_fault),
   .i_status(i_status)
);
`default_nettype wire

// >>> tb/tcesr_host_model.sv
// Serial bus host model that reads and writes the register bank
`timescale 1ns/1ps
`default_nettype none

module tcesr_host_model
   import tcesr_pkg::*;
#(
   parameter logic [6:0] ADDR = 7'h1d
) (
   // Clock
   input  wire logic i_sys_clk,
   // Resolved data line
   input  wire logic i_sda,
   // Host drive, 1 releases to the pull-up
   output var  logic o_scl,
   output var  logic o_sda
);
   // Bus idles released
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : tick

   // Data moves only with SCL low; slave bit taken late in the high phase
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      o_sda <= b;
      tick(3);
      o_scl <= 1'b1;
      tick(3);
      r = i_sda;
      o_scl <= 1'b0;
   endtask : bit_io

   // Also serves as repeated start from a low clock
   task automatic start;
      tick(2);
      o_sda <= 1'b1;
      tick(3);
      o_scl <= 1'b1;
      tick(3);
      o_sda <= 1'b0;
      tick(3);
      o_scl <= 1'b0;
   endtask : start

   task automatic stop;
      tick(2);
      o_sda <= 1'b0;
      tick(3);
      o_scl <= 1'b1;
      tick(3);
      o_sda <= 1'b1;
      tick(3);
   endtask : stop

   task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic s_ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(m_ack, s_ack);
   endtask : byte_io

   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
      logic [7:0] q;
      logic       a0, a1, a2;
      start();
      byte_io({ADDR, 1'b0}, 1'b1, q, a0);
      byte_io(ptr, 1'b1, q, a1);
      byte_io(data, 1'b1, q, a2);
      stop();
      ok = !(a0 | a1 | a2);
   endtask : write_reg

   // Pointer write, repeated start, one byte closed by a NACK
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
      logic [7:0] q;
      logic       a0, a1, a2, a3;
      start();
      byte_io({ADDR, 1'b0}, 1'b1, q, a0);
      byte_io(ptr, 1'b1, q, a1);
      start();
      byte_io({ADDR, 1'b1}, 1'b1, q, a2);
      byte_io(8'hff, 1'b1, data, a3);
      stop();
      ok = !(a0 | a1 | a2) && a3;
   endtask : read_reg

   // Two bytes from one pointer, the first acknowledged by the host
   task automatic read_two(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
      logic [7:0] q;
      logic       a0, a1, a2, a3, a4;
      start();
      byte_io({ADDR, 1'b0}, 1'b1, q, a0);
      byte_io(ptr, 1'b1, q, a1);
      start();
      byte_io({ADDR, 1'b1}, 1'b1, q, a2);
      byte_io(8'hff, 1'b0, data[15:8], a3);
      byte_io(8'hff, 1'b1, data[7:0], a4);
      stop();
      ok = !(a0 | a1 | a2 | a3) && a4;
   endtask : read_two
endmodule : tcesr_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the Type-C event and status register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import tcesr_pkg::*;

   logic          i_sys_clk;
   logic          i_rst_b;
   logic          scl;
   logic          host_sda;
   wire           sda_line;
   logic          sda_drv;
   logic          sda_oe_b;
   logic          irq;
   logic          irq_oe_b;
   tcesr_fault_t  fault;
   tcesr_status_t status;
   int            mismatches = 0;
   int            checks_done = 0;
   int            cycles = 0;

   // Open-drain data line with pull-up
   assign sda_line = host_sda & (sda_oe_b | sda_drv);

   tcesr_top tcesr_top_i (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_scl(scl),
      .i_sda(sda_line),
      .o_sda(sda_drv),
      .o_sda_oe_b(sda_oe_b),
      .o_interrupt_request_pin(irq),
      .o_interrupt_request_pin_oe_b(irq_oe_b),
      .i_fault(fault),
      .i_status(status)
   );

   tcesr_host_model tcesr_host_model_i (
      .i_sys_clk(i_sys_clk),
      .i_sda(sda_line),
      .o_scl(scl),
      .o_sda(host_sda)
   );

   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // Hang guard, well above the roughly 12000 cycles the tests need
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Read carries the acknowledge summary in its top bit
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] v;
      logic       ok;
      tcesr_host_model_i.read_reg(p, v, ok);
      check({ok, v}, {1'b1, e});
   endtask : rd

   // Burst read, pointer moving on after the first byte
   task automatic rd2(input logic [7:0] p, input logic [15:0] e);
      logic [15:0] v;
      logic        ok;
      tcesr_host_model_i.read_two(p, v, ok);
      check({ok, v[15:8]}, {1'b1, e[15:8]});
      check({1'b0, v[7:0]}, {1'b0, e[7:0]});
   endtask : rd2

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic ok;
      tcesr_host_model_i.write_reg(p, d, ok);
      check({ok, 8'h00}, 9'h100);
   endtask : wr

   task automatic drive(input tcesr_fault_t f, input tcesr_status_t s);
      @(posedge i_sys_clk);
      fault <= f;
      status <= s;
   endtask : drive

   // Margin past the one-cycle event latency
   task automatic chk_pin(input logic e);
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check({8'h00, irq_oe_b}, {8'h00, e});
   endtask : chk_pin

   task automatic t_reset;
      chk_pin(1'b1);
      rd(REG_EVENT_FLAGS, 8'h00);
      rd(REG_CONN_STATUS, 8'h00);
      rd(REG_CONTROL, 8'h00);
      rd(8'h10, 8'h00);
      rd(REG_DEVICE_ID, 8'h00);
      $display("reset test done");
   endtask : t_reset

   task automatic t_faults;
      logic [7:0] flag;
      for (int i = 0; i < 3; i++) begin
         flag = (i == 0) ? 8'h40 : (i == 1) ? 8'h20 : 8'h08;
         drive(3'(1 << i), 8'h00);
         chk_pin(1'b0);
         rd(REG_EVENT_FLAGS, flag | 8'h04);
         chk_pin(1'b1);
         rd(REG_EVENT_FLAGS, 8'h04);
         chk_pin(1'b1);
         drive(3'h0, 8'h00);
         chk_pin(1'b0);
         rd(REG_EVENT_FLAGS, 8'h80);
      end
      // Recovery waits until every fault is gone
      drive(3'h3, 8'h00);
      rd(REG_EVENT_FLAGS, 8'h64);
      drive(3'h1, 8'h00);
      chk_pin(1'b1);
      rd(REG_EVENT_FLAGS, 8'h04);
      drive(3'h0, 8'h00);
      rd(REG_EVENT_FLAGS, 8'h80);
      $display("fault test done");
   endtask : t_faults

   // Every partner code but standby, and every current and polarity code, once
   task automatic t_attach;
      tcesr_status_t st;
      for (int i = 1; i <= 4; i++) begin
         st = {i[0], 2'(i - 1), 3'(i), 2'(i - 1)};
         drive(3'h0, st);
         chk_pin(1'b0);
         rd(REG_EVENT_FLAGS, 8'h01);
         rd(REG_CONN_STATUS, st);
         drive(3'h0, 8'h00);
         rd(REG_EVENT_FLAGS, 8'h02);
      end
      // Flags then status in one burst
      drive(3'h0, 8'h84);
      rd2(REG_EVENT_FLAGS, 16'h0184);
      drive(3'h0, 8'h00);
      rd(REG_EVENT_FLAGS, 8'h02);
      $display("attach test done");
   endtask : t_attach

   task automatic t_mask;
      wr(REG_CONTROL, 8'h01);
      rd(REG_CONTROL, 8'h01);
      drive(3'h1, 8'h00);
      chk_pin(1'b1);
      drive(3'h0, 8'h00);
      chk_pin(1'b1);
      rd(REG_EVENT_FLAGS, 8'hc0);
      drive(3'h4, 8'h00);
      chk_pin(1'b1);
      wr(REG_CONTROL, 8'h00);
      chk_pin(1'b0);
      rd(REG_EVENT_FLAGS, 8'h0c);
      chk_pin(1'b1);
      drive(3'h0, 8'h00);
      chk_pin(1'b0);
      rd(REG_EVENT_FLAGS, 8'h80);
      $display("mask test done");
   endtask : t_mask

   initial begin
      i_rst_b = 1'b0;
      fault = '0;
      status = '0;
      repeat (20) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      t_reset();
      t_faults();
      t_attach();
      t_mask();
      summarize();
   end
endmodule : testbench
`default_nettype wire
